// ### design/ppi_defines.svh
// constants for the 24-line parallel i/o block
// assumes inclusion by bare name from every design file but the package
`ifndef PPI_DEFINES_SVH
`define PPI_DEFINES_SVH

`define PPI_DW 8
`define PPI_CW_RESET 8'h9b
`define PPI_CW_FLAG 7
`define PPI_CW_MA_HI 6
`define PPI_CW_MA_LO 5
`define PPI_CW_DIR_A 4
`define PPI_CW_DIR_CU 3
`define PPI_CW_MB 2
`define PPI_CW_DIR_B 1
`define PPI_CW_DIR_CL 0
`define PPI_BSR_IDX_HI 3
`define PPI_BSR_IDX_LO 1
`define PPI_BSR_VAL 0
`define PPI_PC_IRQ_A 3'h3
`define PPI_PC_IRQ_B 3'h0
`define PPI_PC_GATE_B 3'h2
`define PPI_PC_GATE_AI 3'h4
`define PPI_PC_GATE_AO 3'h6
`define PPI_GATE_AI 0
`define PPI_GATE_AO 1
`define PPI_GATE_B 2
`define PPI_NGATE 3
`define PPI_BYTE_ZERO 8'h00
`define PPI_BYTE_ONES 8'hff
`define PPI_GATE_ZERO 3'h0

`endif

// ### design/ppi_pkg.sv
// types shared by the parallel i/o block
// assumes nothing beyond the defines header
`default_nettype none
package ppi_pkg;
	typedef enum logic [1:0] {
		PPI_SEL_A,
		PPI_SEL_B,
		PPI_SEL_C,
		PPI_SEL_CTRL
	} ppi_sel_t;

	typedef enum logic [1:0] {
		PPI_MODE0,
		PPI_MODE1,
		PPI_MODE2,
		PPI_MODE2_ALT
	} ppi_mode_t;
endpackage
`default_nettype wire

// ### design/ppi_cw_dec.sv
// control word field decoder, purely combinational
// assumes the stored word is always a mode definition word
`default_nettype none
`include "ppi_defines.svh"
module ppi_cw_dec import ppi_pkg::*; (
	input wire logic [7:0] i_cw,
	output ppi_mode_t o_mode_a,
	output logic o_mode_b_on,
	output logic o_dir_a_in,
	output logic o_dir_cu_in,
	output logic o_dir_b_in,
	output logic o_dir_cl_in,
	output logic [7:0] o_read_back
);
	always_comb begin
		o_mode_a = ppi_mode_t'(i_cw[`PPI_CW_MA_HI:`PPI_CW_MA_LO]);
		o_mode_b_on = i_cw[`PPI_CW_MB];
		o_dir_a_in = i_cw[`PPI_CW_DIR_A];
		o_dir_cu_in = i_cw[`PPI_CW_DIR_CU];
		o_dir_b_in = i_cw[`PPI_CW_DIR_B];
		o_dir_cl_in = i_cw[`PPI_CW_DIR_CL];
		o_read_back = i_cw;
		o_read_back[`PPI_CW_FLAG] = 1'b1;
	end
endmodule
`default_nettype wire

// ### design/ppi_bsr.sv
// single-bit set/clear decoder for port c and the irq gate flags
// assumes the caller applies the result only on a control write
`default_nettype none
`include "ppi_defines.svh"
module ppi_bsr (
	input wire logic [7:0] i_data,
	input wire logic [7:0] i_pc_q,
	input wire logic [2:0] i_gate_q,
	input wire logic i_grp_a_strobed,
	input wire logic i_grp_b_strobed,
	output logic [7:0] o_pc,
	output logic [2:0] o_gate
);
	logic [2:0] idx;
	logic val;

	always_comb begin
		idx = i_data[`PPI_BSR_IDX_HI:`PPI_BSR_IDX_LO];
		val = i_data[`PPI_BSR_VAL];
		o_pc = i_pc_q;
		o_gate = i_gate_q;
		if (i_grp_a_strobed && idx == `PPI_PC_GATE_AI) begin
			o_gate[`PPI_GATE_AI] = val;
		end else if (i_grp_a_strobed && idx == `PPI_PC_GATE_AO) begin
			o_gate[`PPI_GATE_AO] = val;
		end else if (i_grp_b_strobed && idx == `PPI_PC_GATE_B) begin
			o_gate[`PPI_GATE_B] = val;
		end else begin
			o_pc[idx] = val;
		end
	end
endmodule
`default_nettype wire

// ### design/ppi_top.sv
// 24-line programmable parallel i/o block behind an 8-bit strobed bus
// assumes bus strobes and port pins are synchronous to i_ref_clk
//
// Behaviour
// - host talks through one 8-bit two-way three-state data bus
// - group a owns port a and c7-c4; group b owns b and c3-c0
// - control word can be written and read back
// - reading the control word always shows bit 7 as one
// - port a has separate 8-bit output and input latches
// - port b has one 8-bit latch for either direction
// - port c outputs latched, inputs read live from the pins
// - port c splits into two 4-bit halves with own latches
// - reset makes all 24 lines inputs until a new mode is written
// - port a and b modes independent; c halves follow their group
// - a mode write clears every output latch and status flop
// - one control write sets or clears a single port c bit, or a gate flag for c4/c6 (group a strobed) or c2 (group b strobed)
// - bit set/clear also works on control and status c bits
// - in strobed modes each irq output is gated by its flag
// - gate flags clear on reset and on every mode write
// - mode 0 reads and writes ports with no handshake
// - mode 0 outputs hold last write; a and c inputs read unlatched, b through its latch
// - mode 0 gives two 8-bit and two 4-bit ports, 16 combos
// - d4 port a, d3 upper c, d1 port b, d0 lower c; one is input
`default_nettype none
`include "ppi_defines.svh"
module ppi_top import ppi_pkg::*; #(
	parameter int DW = `PPI_DW
) (
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	input wire logic i_clk_en,
	input wire logic i_reset,
	input wire logic i_cs_n,
	input wire logic i_rd_n,
	input wire logic i_wr_n,
	input wire logic [1:0] i_addr,
	input wire logic [DW-1:0] i_data,
	output logic [DW-1:0] o_data,
	output logic o_data_oe_n,
	input wire logic [DW-1:0] i_pa,
	output logic [DW-1:0] o_pa,
	output logic o_pa_oe_n,
	input wire logic [DW-1:0] i_pb,
	output logic [DW-1:0] o_pb,
	output logic o_pb_oe_n,
	input wire logic [DW-1:0] i_pc,
	output logic [DW-1:0] o_pc,
	output logic [DW-1:0] o_pc_oe_n,
	input wire logic i_irq_req_a,
	input wire logic i_irq_req_b
);
	if (DW != `PPI_DW) begin : g_bad_width
		$error("ppi_top: data width must be 8");
	end

	// bus state
	logic wr_seen_ff, nxt_wr_seen;
	logic rd_on_ff, nxt_rd_on;
	logic [7:0] rdata_ff, nxt_rdata;
	ppi_sel_t rd_sel_ff, nxt_rd_sel;
	// configuration and latch state
	logic [7:0] cw_ff, nxt_cw;
	logic [7:0] pa_out_ff, nxt_pa_out;
	logic [7:0] pa_in_ff, nxt_pa_in;
	logic [7:0] pb_ff, nxt_pb;
	logic [7:0] pc_out_ff, nxt_pc_out;
	logic [2:0] gate_ff, nxt_gate;
	logic [7:0] pc_pin_ff, nxt_pc_pin;

	ppi_sel_t sel;
	ppi_mode_t mode_a;
	logic mode_b_on, dir_a_in, dir_cu_in, dir_b_in, dir_cl_in;
	logic [7:0] cw_rd;
	logic grp_a_strobed, grp_a_mode0;
	logic wr_stb, rd_act;
	logic [7:0] bsr_pc;
	logic [2:0] bsr_gate;
	logic [7:0] pc_drive;
	logic gate_a;

	assign sel = ppi_sel_t'(i_addr);
	assign grp_a_mode0 = (mode_a == PPI_MODE0);
	assign grp_a_strobed = !grp_a_mode0;
	assign rd_act = !i_cs_n && !i_rd_n;
	// a write acts once, at the first cycle the strobe is seen low
	assign wr_stb = i_clk_en && !i_cs_n && !i_wr_n && !wr_seen_ff;

	ppi_cw_dec u_cw_dec (
		.i_cw(cw_ff),
		.o_mode_a(mode_a),
		.o_mode_b_on(mode_b_on),
		.o_dir_a_in(dir_a_in),
		.o_dir_cu_in(dir_cu_in),
		.o_dir_b_in(dir_b_in),
		.o_dir_cl_in(dir_cl_in),
		.o_read_back(cw_rd)
	);

	ppi_bsr u_bsr (
		.i_data(i_data),
		.i_pc_q(pc_out_ff),
		.i_gate_q(gate_ff),
		.i_grp_a_strobed(grp_a_strobed),
		.i_grp_b_strobed(mode_b_on),
		.o_pc(bsr_pc),
		.o_gate(bsr_gate)
	);

	for (genvar i = 0; i < DW; i++) begin : g_pc_drive
		if (i >= DW / 2) begin : g_upper
			assign pc_drive[i] = (grp_a_mode0 && !dir_cu_in) ||
				(grp_a_strobed && i == int'(`PPI_PC_IRQ_A));
		end else begin : g_lower
			assign pc_drive[i] = (!mode_b_on && !dir_cl_in) ||
				(mode_b_on && i == int'(`PPI_PC_IRQ_B)) ||
				(grp_a_strobed && i == int'(`PPI_PC_IRQ_A));
		end
	end

	always_comb begin
		if (mode_a == PPI_MODE0) begin
			gate_a = 1'b0;
		end else if (mode_a == PPI_MODE1) begin
			gate_a = dir_a_in ? gate_ff[`PPI_GATE_AI] :
				gate_ff[`PPI_GATE_AO];
		end else begin
			gate_a = gate_ff[`PPI_GATE_AI] || gate_ff[`PPI_GATE_AO];
		end
	end

	// bus side: read data is captured while the read strobe is low
	always_comb begin
		nxt_wr_seen = !i_cs_n && !i_wr_n;
		nxt_rd_on = rd_act;
		nxt_rd_sel = rd_act ? sel : rd_sel_ff;
		nxt_rdata = rdata_ff;
		if (rd_act) begin
			unique case (sel)
				PPI_SEL_A: begin
					if (grp_a_mode0) begin
						nxt_rdata = dir_a_in ? i_pa : pa_out_ff;
					end else begin
						nxt_rdata = pa_in_ff;
					end
				end
				PPI_SEL_B: nxt_rdata = pb_ff;
				PPI_SEL_C: nxt_rdata = (pc_out_ff & pc_drive) |
					(i_pc & ~pc_drive);
				PPI_SEL_CTRL: nxt_rdata = cw_rd;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wr_seen_ff <= 1'b0;
			rd_on_ff <= 1'b0;
			rd_sel_ff <= PPI_SEL_A;
			rdata_ff <= `PPI_BYTE_ZERO;
		end else if (i_clk_en) begin
			wr_seen_ff <= nxt_wr_seen;
			rd_on_ff <= nxt_rd_on;
			rd_sel_ff <= nxt_rd_sel;
			rdata_ff <= nxt_rdata;
		end
	end

	assign o_data = rdata_ff;
	assign o_data_oe_n = !rd_on_ff;

	// configuration, latches and pins
	always_comb begin
		nxt_cw = cw_ff;
		nxt_pa_out = pa_out_ff;
		nxt_pa_in = i_pa;
		nxt_pb = pb_ff;
		nxt_pc_out = pc_out_ff;
		nxt_gate = gate_ff;
		if (i_reset) begin
			nxt_cw = `PPI_CW_RESET;
			nxt_pa_out = `PPI_BYTE_ZERO;
			nxt_pb = `PPI_BYTE_ZERO;
			nxt_pc_out = `PPI_BYTE_ZERO;
			nxt_gate = `PPI_GATE_ZERO;
		end else begin
			if (dir_b_in) begin
				nxt_pb = i_pb;
			end
			if (wr_stb) begin
				unique case (sel)
					PPI_SEL_A: nxt_pa_out = i_data;
					PPI_SEL_B: begin
						if (!dir_b_in) begin
							nxt_pb = i_data;
						end
					end
					PPI_SEL_C: begin
						// only mode 0 output halves take a port write
						if (grp_a_mode0 && !dir_cu_in) begin
							nxt_pc_out[7:4] = i_data[7:4];
						end
						if (!mode_b_on && !dir_cl_in) begin
							nxt_pc_out[3:0] = i_data[3:0];
						end
					end
					PPI_SEL_CTRL: begin
						if (i_data[`PPI_CW_FLAG]) begin
							nxt_cw = i_data;
							nxt_pa_out = `PPI_BYTE_ZERO;
							nxt_pb = `PPI_BYTE_ZERO;
							nxt_pc_out = `PPI_BYTE_ZERO;
							nxt_gate = `PPI_GATE_ZERO;
						end else begin
							nxt_pc_out = bsr_pc;
							nxt_gate = bsr_gate;
						end
					end
				endcase
			end
		end
		nxt_pc_pin = nxt_pc_out;
		if (grp_a_strobed) begin
			nxt_pc_pin[`PPI_PC_IRQ_A] = i_irq_req_a && gate_a;
		end
		if (mode_b_on) begin
			nxt_pc_pin[`PPI_PC_IRQ_B] = i_irq_req_b &&
				gate_ff[`PPI_GATE_B];
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cw_ff <= `PPI_CW_RESET;
			pa_out_ff <= `PPI_BYTE_ZERO;
			pa_in_ff <= `PPI_BYTE_ZERO;
			pb_ff <= `PPI_BYTE_ZERO;
			pc_out_ff <= `PPI_BYTE_ZERO;
			gate_ff <= `PPI_GATE_ZERO;
			pc_pin_ff <= `PPI_BYTE_ZERO;
		end else if (i_clk_en) begin
			cw_ff <= nxt_cw;
			pa_out_ff <= nxt_pa_out;
			pa_in_ff <= nxt_pa_in;
			pb_ff <= nxt_pb;
			pc_out_ff <= nxt_pc_out;
			gate_ff <= nxt_gate;
			pc_pin_ff <= nxt_pc_pin;
		end
	end

	assign o_pa = pa_out_ff;
	// mode 2 port a drive is left to the strobed logic, not built here
	assign o_pa_oe_n = !(mode_a != PPI_MODE2 && mode_a != PPI_MODE2_ALT &&
		!dir_a_in);
	assign o_pb = pb_ff;
	assign o_pb_oe_n = dir_b_in;
	assign o_pc = pc_pin_ff;
	assign o_pc_oe_n = ~pc_drive;

	property p_cw_flag;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		!o_data_oe_n && rd_sel_ff == PPI_SEL_CTRL |-> o_data[7];
	endproperty
	a_cw_flag: assert property (p_cw_flag)
		else $error("control read shows bit 7 low");

	property p_reset_inputs;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		i_reset && i_clk_en |=> o_pa_oe_n && o_pb_oe_n &&
			o_pc_oe_n == `PPI_BYTE_ONES;
	endproperty
	a_reset_inputs: assert property (p_reset_inputs)
		else $error("a port drives after reset");

	property p_mode_clear;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		wr_stb && !i_reset && sel == PPI_SEL_CTRL && i_data[7]
			|=> o_pa == `PPI_BYTE_ZERO && pc_out_ff == `PPI_BYTE_ZERO;
	endproperty
	a_mode_clear: assert property (p_mode_clear)
		else $error("output latch survives a mode write");

	property p_gate_clear;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		(i_clk_en && i_reset) || (wr_stb && sel == PPI_SEL_CTRL &&
			i_data[7]) |=> gate_ff == `PPI_GATE_ZERO;
	endproperty
	a_gate_clear: assert property (p_gate_clear)
		else $error("gate flag survives reset or mode write");

	property p_bsr_bit;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		wr_stb && !i_reset && sel == PPI_SEL_CTRL && !i_data[7] &&
			grp_a_mode0 && !mode_b_on
			|=> pc_out_ff[$past(i_data[3:1])] == $past(i_data[0]) &&
			gate_ff == $past(gate_ff);
	endproperty
	a_bsr_bit: assert property (p_bsr_bit)
		else $error("bit command missed its port c bit");

	property p_cw_store;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		wr_stb && !i_reset && sel == PPI_SEL_CTRL && i_data[7]
			|=> cw_ff == $past(i_data);
	endproperty
	a_cw_store: assert property (p_cw_store)
		else $error("mode word not stored");

	property p_dir_a;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		grp_a_mode0 |-> o_pa_oe_n == cw_ff[`PPI_CW_DIR_A];
	endproperty
	a_dir_a: assert property (p_dir_a)
		else $error("port a direction disagrees with d4");

	property p_pc_live;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		i_clk_en && rd_act && sel == PPI_SEL_C && pc_drive ==
			`PPI_BYTE_ZERO |=> o_data == $past(i_pc);
	endproperty
	a_pc_live: assert property (p_pc_live)
		else $error("port c read not taken from pins");

	property p_irq_gate;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		i_clk_en && mode_b_on && !gate_ff[`PPI_GATE_B] |=>
			!o_pc[`PPI_PC_IRQ_B];
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("irq passes a cleared gate");

	property p_pa_hold;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		wr_stb && !i_reset && sel == PPI_SEL_A ##1
			(!wr_stb && !i_reset)[*2] |-> o_pa == $past(i_data, 2);
	endproperty
	a_pa_hold: assert property (p_pa_hold)
		else $error("port a output latch lost its value");
endmodule
`default_nettype wire

// ### sim/ppi_pin_model.sv
// peripheral side of the three ports: resolves each pin from both drivers
// assumes the bench supplies the peripheral's own levels on i_*_ext
`default_nettype none
module ppi_pin_model (
	input wire logic [7:0] i_pa_q,
	input wire logic i_pa_oe_n,
	input wire logic [7:0] i_pb_q,
	input wire logic i_pb_oe_n,
	input wire logic [7:0] i_pc_q,
	input wire logic [7:0] i_pc_oe_n,
	input wire logic [7:0] i_pa_ext,
	input wire logic [7:0] i_pb_ext,
	input wire logic [7:0] i_pc_ext,
	output logic [7:0] o_pa,
	output logic [7:0] o_pb,
	output logic [7:0] o_pc
);
	timeunit 1ns;
	timeprecision 1ps;
	// the peripheral only drives a line the device has released
	assign o_pa = i_pa_oe_n ? i_pa_ext : i_pa_q;
	assign o_pb = i_pb_oe_n ? i_pb_ext : i_pb_q;
	// port c resolves per bit, halves may differ
	assign o_pc = (i_pc_oe_n & i_pc_ext) | (~i_pc_oe_n & i_pc_q);
endmodule
`default_nettype wire

// ### sim/tb_programmable_parallel_io_mode0.sv
// self-checking bench for the 24-line parallel i/o block
// assumes ppi_top and the pin model; bus held until each edge is sampled
`default_nettype none
module tb_programmable_parallel_io_mode0 import ppi_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_ref_clk = 1'b0;
	logic i_arst_n = 1'b0;
	logic rst = 1'b0;
	logic clk_en = 1'b1;
	logic cs_n = 1'b1;
	logic rd_n = 1'b1;
	logic wr_n = 1'b1;
	logic [1:0] addr = 2'h0;
	logic [7:0] wdata = 8'h00;
	logic irq_a = 1'b0;
	logic irq_b = 1'b0;
	logic [7:0] ext_pa = 8'ha5;
	logic [7:0] ext_pb = 8'h3c;
	logic [7:0] ext_pc = 8'he7;
	logic [7:0] o_data, o_pa, o_pb, o_pc, pc_oe_n, pa, pb, pc;
	logic data_oe_n, pa_oe_n, pb_oe_n;
	int n_mismatch = 0;
	int tests_run = 0;
	int cycles = 0;

	always #12.5 i_ref_clk = ~i_ref_clk;

	ppi_top i_dut (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
		.i_clk_en(clk_en), .i_reset(rst), .i_cs_n(cs_n), .i_rd_n(rd_n),
		.i_wr_n(wr_n), .i_addr(addr), .i_data(wdata), .o_data(o_data),
		.o_data_oe_n(data_oe_n), .i_pa(pa), .o_pa(o_pa),
		.o_pa_oe_n(pa_oe_n), .i_pb(pb), .o_pb(o_pb), .o_pb_oe_n(pb_oe_n),
		.i_pc(pc), .o_pc(o_pc), .o_pc_oe_n(pc_oe_n),
		.i_irq_req_a(irq_a), .i_irq_req_b(irq_b));

	ppi_pin_model i_pins (.i_pa_q(o_pa), .i_pa_oe_n(pa_oe_n),
		.i_pb_q(o_pb), .i_pb_oe_n(pb_oe_n), .i_pc_q(o_pc),
		.i_pc_oe_n(pc_oe_n), .i_pa_ext(ext_pa), .i_pb_ext(ext_pb),
		.i_pc_ext(ext_pc), .o_pa(pa), .o_pb(pb), .o_pc(pc));

	task automatic end_sim;
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// a hung bus task would otherwise never return
	always @(posedge i_ref_clk) begin
		cycles <= cycles + 1;
		if (cycles >= 5000) begin
			n_mismatch++;
			end_sim();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		cs_n <= 1'b0;
		wr_n <= 1'b0;
		addr <= a;
		wdata <= d;
		@(posedge i_ref_clk);
		@(posedge i_ref_clk);
		cs_n <= 1'b1;
		wr_n <= 1'b1;
		@(posedge i_ref_clk);
		#1;
	endtask

	task automatic rd(input logic [1:0] a, input logic [7:0] exp);
		@(posedge i_ref_clk);
		cs_n <= 1'b0;
		rd_n <= 1'b0;
		addr <= a;
		@(posedge i_ref_clk);
		@(posedge i_ref_clk);
		#1;
		chk({7'h0, data_oe_n}, 8'h00);
		chk(o_data, exp);
		@(posedge i_ref_clk);
		cs_n <= 1'b1;
		rd_n <= 1'b1;
		@(posedge i_ref_clk);
		@(posedge i_ref_clk);
		#1;
		chk({7'h0, data_oe_n}, 8'h01);
	endtask

	task automatic t_reset;
		chk({6'h0, pa_oe_n, pb_oe_n}, 8'h03);
		chk(pc_oe_n, 8'hff);
		rd(2'h3, 8'h9b);
	endtask

	task automatic t_dirs;
		logic [7:0] cw;
		for (int k = 0; k < 16; k++) begin
			cw = {4'h8, 1'b0, k[3], k[2], 1'b0} | {6'h0, k[1], k[0]};
			cw = {cw[7:5], k[3], k[2], 1'b0, k[1], k[0]};
			wr(2'h3, cw);
			chk({6'h0, pa_oe_n, pb_oe_n}, {6'h0, k[3], k[1]});
			chk(pc_oe_n, {{4{k[2]}}, {4{k[0]}}});
			rd(2'h3, cw);
		end
	endtask

	task automatic t_latch;
		wr(2'h3, 8'h80);
		wr(2'h0, 8'h5a);
		wr(2'h1, 8'hc3);
		wr(2'h2, 8'h96);
		chk(o_pa, 8'h5a);
		chk(o_pb, 8'hc3);
		chk(o_pc, 8'h96);
		rd(2'h0, 8'h5a);
		rd(2'h1, 8'hc3);
		rd(2'h2, 8'h96);
		wr(2'h3, 8'h88);
		chk(o_pa | o_pb, 8'h00);
		rd(2'h2, 8'he0);
		wr(2'h2, 8'h0f);
		rd(2'h2, 8'hef);
		wr(2'h3, 8'h9b);
		rd(2'h0, 8'ha5);
		@(posedge i_ref_clk);
		ext_pa <= 8'h11;
		ext_pc <= 8'h42;
		rd(2'h0, 8'h11);
		rd(2'h2, 8'h42);
		rd(2'h1, 8'h3c);
	endtask

	task automatic t_bsr;
		logic [7:0] exp;
		exp = 8'h00;
		wr(2'h3, 8'h80);
		for (int i = 0; i < 8; i++) begin
			wr(2'h3, {4'h0, i[2:0], 1'b1});
			exp[i] = 1'b1;
			chk(o_pc, exp);
		end
		for (int i = 7; i >= 0; i -= 2) begin
			wr(2'h3, {4'h0, i[2:0], 1'b0});
			exp[i] = 1'b0;
			chk(o_pc, exp);
		end
		wr(2'h3, 8'h80);
		chk(o_pc, 8'h00);
	endtask

	task automatic t_gate;
		@(posedge i_ref_clk);
		irq_a <= 1'b1;
		irq_b <= 1'b1;
		wr(2'h3, 8'hb0);
		chk({7'h0, o_pc[3]}, 8'h00);
		wr(2'h3, 8'h09);
		chk({7'h0, o_pc[3]}, 8'h01);
		wr(2'h3, 8'h08);
		chk({7'h0, o_pc[3]}, 8'h00);
		wr(2'h3, 8'h09);
		wr(2'h3, 8'hb0);
		chk({7'h0, o_pc[3]}, 8'h00);
		wr(2'h3, 8'h84);
		chk({7'h0, o_pc[0]}, 8'h00);
		wr(2'h3, 8'h05);
		chk({7'h0, o_pc[0]}, 8'h01);
		// request still raised, so only the cleared gate can block it
		wr(2'h3, 8'h04);
		chk({7'h0, o_pc[0]}, 8'h00);
		wr(2'h3, 8'ha0);
		chk({7'h0, pa_oe_n}, 8'h00);
		wr(2'h3, 8'h0d);
		chk({7'h0, o_pc[3]}, 8'h01);
		wr(2'h3, 8'hc0);
		chk({7'h0, o_pc[3]}, 8'h00);
		wr(2'h3, 8'h09);
		chk({7'h0, o_pc[3]}, 8'h01);
		rd(2'h0, 8'h11);
	endtask

	task automatic t_hw_reset;
		wr(2'h3, 8'h80);
		wr(2'h0, 8'hff);
		@(posedge i_ref_clk);
		rst <= 1'b1;
		wr(2'h3, 8'h80);
		chk({6'h0, pa_oe_n, pb_oe_n}, 8'h03);
		chk(pc_oe_n, 8'hff);
		@(posedge i_ref_clk);
		rst <= 1'b0;
		rd(2'h3, 8'h9b);
		chk(o_pa, 8'h00);
	endtask

	// a low enable must freeze the write detector as well as the latches
	task automatic t_freeze;
		wr(2'h3, 8'h80);
		@(posedge i_ref_clk);
		clk_en <= 1'b0;
		wr(2'h0, 8'h77);
		chk(o_pa, 8'h00);
		@(posedge i_ref_clk);
		clk_en <= 1'b1;
		wr(2'h0, 8'h77);
		chk(o_pa, 8'h77);
	endtask

	initial begin
		repeat (6) @(posedge i_ref_clk);
		i_arst_n <= 1'b1;
		#1;
		t_reset();
		t_dirs();
		t_latch();
		t_bsr();
		t_gate();
		t_freeze();
		t_hw_reset();
		end_sim();
	end
endmodule
`default_nettype wire
